/* File: dv/tsh_core_model.sv */
// endpoint core model: takes stream words, grants accept, reports credit levels
`timescale 1ns/10ps
module tsh_core_model (
  // clocking
  input  wire logic        core_clk,
  input  wire logic        srst,
  // stream from the feeder
  input  wire logic [31:0] tx_data,
  input  wire logic        stream_word_valid,
  input  wire logic        tx_pkt_last,
  output logic             tx_accept,
  // bench controls and credits: posted, nonposted, initial posted, completion
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic [47:0] cred_cfg,
  output logic [11:0]      cp, cn, ci, cc,
  // observation
  output logic [15:0]      pkt_cnt,
  output logic [15:0]      word_cnt,
  output logic [31:0]      last_word
);
  logic tog_q;
  assign {cp, cn, ci, cc} = cred_cfg;
  // no accept while posted credit is exhausted; slow mode grants every other cycle
  assign tx_accept = !stall && !(slow && tog_q) && (cp != 12'h000);
  // count words and packets as they are taken
  always_ff @(posedge core_clk)
  begin
    tog_q <= srst ? 1'b0 : !tog_q;
    pkt_cnt <= srst ? 16'h0000 : pkt_cnt + {15'h0000, stream_word_valid && tx_accept && tx_pkt_last};
    word_cnt <= srst ? 16'h0000 : word_cnt + {15'h0000, stream_word_valid && tx_accept};
    last_word <= (stream_word_valid && tx_accept) ? tx_data : last_word;
  end
endmodule : tsh_core_model

/* File: dv/tsh_feeder_properties.sv */
// checker: stream framing, hang monitor and fifo-full properties of the feeder
`timescale 1ns/10ps
module tsh_feeder_chk (
  // clocking
  input wire logic        core_clk, srst, clk_en,
  // apb
  input wire logic        psel, penable, pwrite, pready,
  input wire logic [7:0]  paddr,
  // stream and debug
  input wire logic [31:0] tx_data,
  input wire logic        stream_word_valid, tx_pkt_first, tx_pkt_last, tx_accept, hang_flag, fifo_full
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire take = stream_word_valid && tx_accept;
  logic        in_pkt_q;
  logic [7:0]  low_q;
  logic [11:0] wcnt_q, need_q;
  // packet tracking and accept-low run length; saturates so a long stall cannot wrap
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      in_pkt_q <= 1'b0;
      low_q <= 8'h00;
      wcnt_q <= 12'h000;
      need_q <= 12'h000;
    end
    else if (clk_en)
    begin
      in_pkt_q <= take ? !tx_pkt_last : in_pkt_q;
      low_q <= tx_accept ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
      wcnt_q <= (take && tx_pkt_first) ? 12'h001 : wcnt_q + {11'h000, take};
      need_q <= (take && tx_pkt_first) ? 12'h002 + {11'h000, tx_data[tsh_pkg::HDR_TD_BIT]}
        + ((tx_data[31:24] == tsh_pkg::FMT_MWR32) ? {2'b00, tx_data[9:0]} : 12'h000) : need_q;
    end
  end
  property p_one_first; in_pkt_q && stream_word_valid |-> !tx_pkt_first; endproperty
  a_one_first: assert property (p_one_first) else $error("first marker inside a packet");
  property p_last_in; stream_word_valid && tx_pkt_last |-> in_pkt_q; endproperty
  a_last_in: assert property (p_last_in) else $error("last marker without first");
  property p_mark_valid; tx_pkt_first || tx_pkt_last |-> stream_word_valid; endproperty
  a_mark_valid: assert property (p_mark_valid) else $error("marker without valid");
  property p_hang_set; low_q >= 8'h65 |-> hang_flag; endproperty
  a_hang_set: assert property (p_hang_set) else $error("hang not flagged");
  property p_hang_early; $rose(hang_flag) |-> low_q >= 8'h65; endproperty
  a_hang_early: assert property (p_hang_early) else $error("hang flagged too soon");
  property p_hang_stick; hang_flag |=> hang_flag; endproperty
  a_hang_stick: assert property (p_hang_stick) else $error("hang flag cleared");
  property p_hold; stream_word_valid && !tx_accept |=> stream_word_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("word dropped while held off");
  property p_len; take && tx_pkt_last |-> wcnt_q + 12'h001 == need_q; endproperty
  a_len: assert property (p_len) else $error("word count differs from header");
  property p_full; psel && penable && pwrite && paddr == tsh_pkg::REG_DATA && fifo_full |-> !pready; endproperty
  a_full: assert property (p_full) else $error("push accepted while full");
  c_pkt: cover property (take && tx_pkt_last);
  c_hang: cover property ($rose(hang_flag));
  c_full: cover property (fifo_full && psel && penable && !pready);
endmodule : tsh_feeder_chk
bind tsh_feeder tsh_feeder_chk i_chk (
  .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .tx_data(tx_data), .stream_word_valid(stream_word_valid),
  .tx_pkt_first(tx_pkt_first), .tx_pkt_last(tx_pkt_last), .tx_accept(tx_accept), .hang_flag(hang_flag),
  .fifo_full(fifo_full)
);

/* File: dv/tsh_feeder_tb_top.sv */
// bench: apb-driven packet scenarios against the core model
`timescale 1ns/10ps
module tsh_feeder_tb_top;
  logic        core_clk, srst, psel, penable, pwrite, stall, slow, pready, pslverr, e;
  logic        stream_word_valid, tx_pkt_first, tx_pkt_last, tx_accept, hang_flag, fifo_full;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, w0, tx_data;
  logic [3:0]  tx_byte_en;
  logic [11:0] cp, cn, ci, cc;
  logic [47:0] cfg;
  logic [15:0] pkt_cnt, word_cnt, p0, n0;
  int          error_cnt, total_checks;
  localparam logic [47:0] CFG0 = 48'h040_010_040_040;
  // refusal table: length 0, 4k crossing, over max payload, over initial credit, read over completion credit
  logic [31:0] rh [5] = '{32'h40000000, 32'h40000002, 32'h40000021, 32'h40000014, 32'h00000004};
  logic [31:0] ra [5] = '{32'h100, 32'hffc, 32'h0, 32'h0, 32'h0};
  logic [47:0] rc [5] = '{CFG0, CFG0, CFG0, 48'h040_010_001_040, 48'h040_010_040_000};
  logic [31:0] last_word_w;
  tsh_feeder i_dut (
    .core_clk(core_clk), .srst(srst), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .stream_word_valid(stream_word_valid), .tx_pkt_first(tx_pkt_first), .tx_pkt_last(tx_pkt_last),
    .tx_byte_en(tx_byte_en), .tx_accept(tx_accept), .tx_cred_posted(cp), .tx_cred_nonposted(cn),
    .init_cred_posted(ci), .cpl_cred_avail(cc), .hang_flag(hang_flag), .fifo_full(fifo_full)
  );
  tsh_core_model i_core (
    .core_clk(core_clk), .srst(srst), .tx_data(tx_data), .stream_word_valid(stream_word_valid),
    .tx_pkt_last(tx_pkt_last), .tx_accept(tx_accept), .stall(stall), .slow(slow), .cred_cfg(cfg), .cp(cp),
    .cn(cn), .ci(ci), .cc(cc), .pkt_cnt(pkt_cnt), .word_cnt(word_cnt), .last_word(last_word_w)
  );
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bail(input bit hit);
    if (hit)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : bail
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 500);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bail(n >= 500);
  endtask : apb
  task automatic stat();
    apb(1'b0, tsh_pkg::REG_STATUS, 32'h0);
  endtask : stat
  task automatic push(input int k);
    for (int i = 0; i < k; i++)
    begin
      w0 = 32'h1000 + i;
      apb(1'b1, tsh_pkg::REG_DATA, w0);
    end
  endtask : push
  task automatic send(input logic [31:0] hdr, input logic [31:0] adr, input logic [31:0] ctl);
    p0 = pkt_cnt;
    n0 = word_cnt;
    apb(1'b1, tsh_pkg::REG_HDR0, hdr);
    apb(1'b1, tsh_pkg::REG_ADDR, adr);
    apb(1'b1, tsh_pkg::REG_CTRL, ctl);
  endtask : send
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      stat();
      n++;
    end
    while (q[tsh_pkg::ST_BUSY] !== 1'b0 && n < 300);
    bail(n >= 300);
  endtask : wait_idle
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // watchdog: a hang of the whole run counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bail(1'b1);
  end
  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata, stall, slow, cfg} = {4'h8, 8'h00, 32'h0, 2'b00, CFG0};
    error_cnt = 0;
    total_checks = 0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    stat();
    check("status", q & 32'h1f, 32'h0);
    apb(1'b0, tsh_pkg::REG_CREDIT, 32'h0);
    check("credit", q, 32'h00010040);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    // two-word write under slow accept, then one word with digest
    slow <= 1'b1;
    push(2);
    send(32'h40000002, 32'h100, 32'h5);
    wait_idle();
    check("pkts", pkt_cnt, p0 + 16'h1);
    check("words", word_cnt, n0 + 16'h4);
    check("last", last_word_w, w0);
    push(1);
    send(32'h40008001, 32'h104, 32'h7);
    wait_idle();
    check("digest words", word_cnt, n0 + 16'h4);
    // refused packets never reach the core
    for (int i = 0; i < 5; i++)
    begin
      cfg <= rc[i];
      send(rh[i], ra[i], (rh[i][31:24] == tsh_pkg::FMT_MWR32) ? 32'h5 : 32'h1);
      wait_idle();
      check("refused", {q[tsh_pkg::ST_REJECT], pkt_cnt}, {1'b1, p0});
    end
    cfg <= CFG0;
    send(32'h00000004, 32'h200, 32'h1);
    wait_idle();
    check("read words", word_cnt, n0 + 16'h2);
    // posted credit exhausted: feeder waits, then goes once credit returns
    cfg <= 48'h000_010_040_040;
    push(1);
    send(32'h40000001, 32'h300, 32'h5);
    stat();
    check("cred wait", {q[tsh_pkg::ST_WAIT], pkt_cnt}, {1'b1, p0});
    cfg <= CFG0;
    wait_idle();
    check("cred go", pkt_cnt, p0 + 16'h1);
    // fill the fifo while the core stalls, hang flagged, then a blocked push drains
    stall <= 1'b1;
    slow <= 1'b0;
    push(8);
    stat();
    check("full", {fifo_full, q[tsh_pkg::ST_FULL]}, 2'b11);
    send(32'h40000009, 32'h400, 32'h5);
    repeat (110) @(posedge core_clk);
    check("hang", hang_flag, 1'b1);
    fork
      apb(1'b1, tsh_pkg::REG_DATA, 32'hbad);
      begin
        repeat (5) @(posedge core_clk);
        stall <= 1'b0;
      end
    join
    wait_idle();
    check("long words", {16'h0, word_cnt}, {16'h0, n0 + 16'hb});
    check("long last", last_word_w, 32'hbad);
    check("sticky", {hang_flag, fifo_full}, 2'b10);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check("hang reset", hang_flag, 1'b0);
    tally_and_finish();
  end
endmodule : tsh_feeder_tb_top

/* File: rtl/tsh_feeder.sv */
// transmit stream feeder: apb-driven packet sender with payload fifo and hang monitor
// Summary of operation
// - a new first marker is sent only after the previous packet's last marker.
// - a last marker always follows exactly one first marker of the same packet.
// - first and last markers are qualified by stream_word_valid, except tx_pkt_last on the last payload word while the fifo is empty.
// - flag a hang when tx_accept stays low more than 100 cycles.
// - compare credits for the packet type against the need before starting.
// - refuse packets whose payload exceeds the advertised initial credit.
// - the number of payload words sent equals the header length field.
// - byte enables: full first and last enables for multi-word, nonzero single.
// - format and type come from a fixed legal table, write or read.
// - with digest bit set, append the crc word as the last word.
// - refuse payloads that cross a 4KByte aligned boundary.
// - refuse memory writes longer than the maximum payload size.
// - refuse reads whose data exceeds the completion credit available.
// - transmit fifo full is exported to status and a port.
`timescale 1ns/10ps

module tsh_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // clocking
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // status
  output logic                  full
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // full only at the full count; the narrow pointer width cannot hold the depth itself
  assign full      = (cnt_q == (AW+1)'(DEPTH));
  assign in_ready  = ~full;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // pointer and count update; storage is not reset to save area
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : tsh_fifo

module tsh_feeder (
  // clocking
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // transmit stream toward the core
  output logic [31:0]      tx_data,
  output logic             stream_word_valid,
  output logic             tx_pkt_first,
  output logic             tx_pkt_last,
  output logic [3:0]       tx_byte_en,
  input  wire logic        tx_accept,
  // credits from the core
  input  wire logic [11:0] tx_cred_posted,
  input  wire logic [11:0] tx_cred_nonposted,
  input  wire logic [11:0] init_cred_posted,
  input  wire logic [11:0] cpl_cred_avail,
  // debug
  output logic             hang_flag,
  output logic             fifo_full
);
  tsh_pkg::tsh_state_t state_q;
  tsh_pkg::tsh_state_t state_d;
  logic [31:0] ctrl_q;
  logic [31:0] hdr0_q;
  logic [31:0] addr_q;
  logic [9:0]  sent_q;
  logic        hang_q;
  logic        reject_q;
  logic [7:0]  hang_cnt_q;
  logic [31:0] crc_q;

  // apb decode
  wire        acc       = psel & penable;
  wire        wr_acc    = acc & pwrite;
  wire        sel_ctrl  = (paddr == tsh_pkg::REG_CTRL);
  wire        sel_hdr   = (paddr == tsh_pkg::REG_HDR0);
  wire        sel_addr  = (paddr == tsh_pkg::REG_ADDR);
  wire        sel_data  = (paddr == tsh_pkg::REG_DATA);
  wire        sel_stat  = (paddr == tsh_pkg::REG_STATUS);
  wire        sel_cred  = (paddr == tsh_pkg::REG_CREDIT);
  wire        mapped    = sel_ctrl | sel_hdr | sel_addr | sel_data | sel_stat | sel_cred;
  wire        idle      = (state_q == tsh_pkg::S_IDLE);
  wire        go_wr     = wr_acc & sel_ctrl & pwdata[tsh_pkg::CTRL_GO] & idle;
  // data writes stall while the fifo is full so back-pressure reaches software
  wire        fifo_in_ready;
  wire        data_push = acc & pwrite & sel_data;
  assign pready  = ~(data_push & ~fifo_in_ready);
  assign pslverr = acc & ~mapped;

  // packet parameters
  wire [9:0]  len_dw   = hdr0_q[tsh_pkg::HDR_LEN_LSB +: 10];
  wire        is_wr    = ctrl_q[tsh_pkg::CTRL_MWR];
  wire        digest   = ctrl_q[tsh_pkg::CTRL_DIGEST];
  wire [7:0]  fmt_type = is_wr ? tsh_pkg::FMT_MWR32 : tsh_pkg::FMT_MRD32;
  wire [31:0] hdr_word = {fmt_type, hdr0_q[23:16], digest, hdr0_q[14:10], len_dw};
  wire [12:0] end_off  = {1'b0, addr_q[11:0]} + {1'b0, len_dw, 2'b00};
  wire        cross4k  = is_wr & end_off[12] & (end_off[11:0] != 12'h000);
  wire        too_big  = is_wr & (len_dw > tsh_pkg::MAX_PAYLOAD_DW);
  wire        over_init = is_wr & ({2'b00, len_dw} > init_cred_posted);
  wire        over_cpl = ~is_wr & ({2'b00, len_dw} > cpl_cred_avail);
  wire [11:0] need     = is_wr ? {2'b00, len_dw} : 12'h001;
  wire [11:0] have     = is_wr ? tx_cred_posted : tx_cred_nonposted;
  wire        cred_ok  = (have >= need);
  wire        bad      = cross4k | too_big | over_init | over_cpl | (len_dw == 10'h000);

  // payload fifo
  wire        pay_valid;
  wire [31:0] pay_data;
  wire        pay_pop  = (state_q == tsh_pkg::S_PAY) & tx_accept;
  tsh_fifo #(.WIDTH(tsh_pkg::DATA_W), .DEPTH(tsh_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .in_valid  (data_push),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata),
    .out_valid (pay_valid),
    .out_ready (pay_pop),
    .out_data  (pay_data),
    .full      (fifo_full)
  );

  // last payload word of the packet
  wire last_pay = (sent_q == len_dw - 10'h001);

  // sender next state; one packet at a time keeps first/last paired
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      tsh_pkg::S_IDLE: if (go_wr) state_d = tsh_pkg::S_CHK;
      tsh_pkg::S_CHK:  if (bad) state_d = tsh_pkg::S_IDLE;
                       else if (cred_ok) state_d = tsh_pkg::S_HDR;
      tsh_pkg::S_HDR:  if (tx_accept) state_d = tsh_pkg::S_ADR;
      tsh_pkg::S_ADR:  if (tx_accept) state_d = is_wr ? tsh_pkg::S_PAY
                                                     : (digest ? tsh_pkg::S_CRC : tsh_pkg::S_IDLE);
      tsh_pkg::S_PAY:  if (tx_accept & pay_valid & last_pay) state_d = digest ? tsh_pkg::S_CRC : tsh_pkg::S_IDLE;
      tsh_pkg::S_CRC:  if (tx_accept) state_d = tsh_pkg::S_IDLE;
      default:         state_d = tsh_pkg::S_IDLE;
    endcase
  end

  // stream outputs are combinational from state; tx_pkt_last can rise in S_PAY with the fifo empty while valid is low
  assign stream_word_valid = (state_q == tsh_pkg::S_HDR) | (state_q == tsh_pkg::S_ADR)
                           | (state_q == tsh_pkg::S_CRC) | ((state_q == tsh_pkg::S_PAY) & pay_valid);
  assign tx_pkt_first = (state_q == tsh_pkg::S_HDR);
  assign tx_pkt_last  = ((state_q == tsh_pkg::S_ADR) & ~is_wr & ~digest)
                      | ((state_q == tsh_pkg::S_PAY) & last_pay & ~digest)
                      | (state_q == tsh_pkg::S_CRC);
  assign tx_byte_en   = 4'hf; // whole dwords only; partial enables not offered
  assign tx_data      = (state_q == tsh_pkg::S_HDR) ? hdr_word
                      : (state_q == tsh_pkg::S_ADR) ? {addr_q[31:2], 2'b00}
                      : (state_q == tsh_pkg::S_CRC) ? crc_q : pay_data;

  // control registers, state and payload counter
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q  <= tsh_pkg::S_IDLE;
      ctrl_q   <= 32'h0000_0000;
      hdr0_q   <= 32'h0000_0000;
      addr_q   <= 32'h0000_0000;
      sent_q   <= 10'h000;
      reject_q <= 1'b0;
      crc_q    <= 32'hffff_ffff;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      if (wr_acc & sel_ctrl & idle)
        ctrl_q <= pwdata;
      if (wr_acc & sel_hdr & idle)
        hdr0_q <= pwdata;
      if (wr_acc & sel_addr & idle)
        addr_q <= pwdata;
      if (state_q == tsh_pkg::S_CHK)
        reject_q <= bad;
      if (state_q == tsh_pkg::S_HDR)
        sent_q <= 10'h000;
      else if (pay_pop & pay_valid)
        sent_q <= sent_q + 10'h001;
      // simple running check word; a real ecrc generator would replace this
      if (state_q == tsh_pkg::S_HDR)
        crc_q <= 32'hffff_ffff ^ hdr_word;
      else if (stream_word_valid & tx_accept & (state_q != tsh_pkg::S_CRC))
        crc_q <= {crc_q[30:0], crc_q[31]} ^ tx_data;
    end
  end

  // hang monitor: counter saturates past the limit, flag sticky until reset
  wire hang_hit = (hang_cnt_q >= tsh_pkg::HANG_LIMIT_C);
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hang_cnt_q <= 8'h00;
      hang_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tx_accept)
        hang_cnt_q <= 8'h00;
      else if (~hang_q)
        hang_cnt_q <= hang_cnt_q + 8'h01;
      if (~tx_accept & hang_hit)
        hang_q <= 1'b1;
    end
  end
  assign hang_flag = hang_q;

  // read mux
  wire [31:0] status_w = {27'h0, (state_q == tsh_pkg::S_CHK) & ~cred_ok, reject_q,
                          fifo_full, hang_q, ~idle} ;
  assign prdata = sel_ctrl ? ctrl_q
                : sel_hdr  ? hdr0_q
                : sel_addr ? addr_q
                : sel_stat ? {status_w[31:5], status_w[4:0]}
                : sel_cred ? {8'h00, tx_cred_nonposted, tx_cred_posted}
                : 32'h0000_0000;
endmodule : tsh_feeder

/* File: rtl/tsh_pkg.sv */
// package: constants and types for the transmit stream feeder with hang monitor
package tsh_pkg;
  // stream geometry
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned CRED_W       = 12;
  // hang monitor: flag when accept stays low more than this many cycles
  localparam int unsigned HANG_LIMIT   = 100;
  localparam int unsigned HANG_CNT_W   = 8;
  localparam logic [7:0]  HANG_LIMIT_C = 8'h64;
  // payload limits (dwords)
  localparam logic [9:0]  MAX_PAYLOAD_DW = 10'h020;
  localparam logic [11:0] PAGE_MASK      = 12'hfff;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_HDR0   = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_DATA   = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CREDIT = 8'h14;
  // ctrl fields
  localparam int unsigned CTRL_GO      = 0;
  localparam int unsigned CTRL_DIGEST  = 1;
  localparam int unsigned CTRL_MWR     = 2;
  // header fields in hdr0
  localparam int unsigned HDR_LEN_LSB  = 0;
  localparam int unsigned HDR_TD_BIT   = 15;
  localparam int unsigned HDR_TYPE_LSB = 24;
  localparam logic [7:0]  FMT_MWR32    = 8'h40;
  localparam logic [7:0]  FMT_MRD32    = 8'h00;
  // status fields
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_HANG   = 1;
  localparam int unsigned ST_FULL   = 2;
  localparam int unsigned ST_REJECT = 3;
  localparam int unsigned ST_WAIT   = 4;
  // sender states, gray coded along the usual path
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHK  = 3'b001,
    S_HDR  = 3'b011,
    S_ADR  = 3'b010,
    S_PAY  = 3'b110,
    S_CRC  = 3'b111
  } tsh_state_t;
endpackage : tsh_pkg
